//--- core/bst_pkg.sv
// Purpose: Shared constants and types of the boundary scan test port.
// Assumes: Four-bit instruction register and a 24-cell boundary path.
// Notes:   The test port module and the testbench both use this package.
`default_nettype none
package bst_pkg;
  // Instruction encodings
  localparam logic [3:0] IR_BYPASS   = 4'h0;
  localparam logic [3:0] IR_PRELOAD  = 4'h1;  // Also sample
  localparam logic [3:0] IR_IDCODE   = 4'h2;
  localparam logic [3:0] IR_USERCODE = 4'h3;
  localparam logic [3:0] IR_CLAMP    = 4'h4;
  localparam logic [3:0] IR_HIGHZ    = 4'h5;
  localparam logic [3:0] IR_EXTEST   = 4'h7;
  localparam logic [3:0] IR_IFONOFF  = 4'h8;
  localparam logic [3:0] IR_REGRD    = 4'h9;
  localparam logic [3:0] IR_REGWR    = 4'hA;
  localparam logic [3:0] IR_CAPTURE  = 4'h1;  // Fixed 01 pattern in the low bits
  // Data register lengths
  localparam int DR_MAX     = 32;
  localparam int LEN_BYPASS = 1;
  localparam int LEN_BSR    = 24;
  localparam int LEN_ID     = 32;
  // Pads: 11 with data and control cells, plus one input-only pad
  localparam int NPAD      = 12;
  localparam int NCTL      = 11;
  localparam int LOW_PADS  = 3;   // Pads below the split sit under cell 6
  localparam int PAD_IF3   = 3;
  localparam int PAD_IF2   = 4;
  localparam int CELL_OUT2 = 7;   // Extra output cell of the IF2 pad
  localparam int CELL_IN   = 6;   // Input-only cell of the IF3 pad
  localparam int NSYNC     = 68;  // Product, version, core out, core oe, pad in
  // Reset values
  localparam logic ID_LSB = 1'b1;
  // TAP controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR   = 16'h0001,
    ST_RTI   = 16'h0002,
    ST_SELDR = 16'h0004,
    ST_CAPDR = 16'h0008,
    ST_SHDR  = 16'h0010,
    ST_EX1DR = 16'h0020,
    ST_PAUDR = 16'h0040,
    ST_EX2DR = 16'h0080,
    ST_UPDR  = 16'h0100,
    ST_SELIR = 16'h0200,
    ST_CAPIR = 16'h0400,
    ST_SHIR  = 16'h0800,
    ST_EX1IR = 16'h1000,
    ST_PAUIR = 16'h2000,
    ST_EX2IR = 16'h4000,
    ST_UPIR  = 16'h8000
  } bst_state_t;
endpackage
`default_nettype wire

//--- core/bst_tap.sv
// Purpose: Boundary scan test port with pad cells and register access.
// Assumes: tck/tms/tdi come from an external test controller.
// Notes:   Test logic runs on tck; register access crosses to core_clk.
// How it works
// - Test logic clocked by tck only
// - Stopped tck keeps state and registers
// - Pull-ups enabled on tck, tms, tdi
// - tms sampled on rising tck edge
// - Five tms highs reach Test-Logic-Reset
// - Test-Logic-Reset loads IDCODE instruction
// - tdi routed into selected chain
// - tdo changes on falling tck edge
// - tdo undriven outside shift states
// - Bypass passes tdi to tdo
// - Data chain length follows instruction
// - Cells override pins under test instructions
// - Twenty-four cells, extra cells 7, 6
// - Data, input and enable cell types
// - ID code fields with LSB one
// - User code is product ID, version
// - Interface off bit taken at Update-DR
// - Read captures data, updates address
// - Write takes address, data at capture
// - Fixed instruction encodings, 7/8-bit access
`timescale 1ns/1ps
`default_nettype none
module bst_tap #(
  parameter logic [3:0]  ID_VERSION = 4'h0,    // Arbitrary value
  parameter logic [15:0] ID_PART    = 16'h0000, // Arbitrary value
  parameter logic [10:0] ID_MANUF   = 11'h000,  // Arbitrary value
  parameter int          REG_AW     = 7,
  parameter int          REG_DW     = 8
) (
  // Core clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              core_ce,
  // Test port pins
  input  wire logic              tck,
  input  wire logic              tms,
  input  wire logic              tdi,
  output logic                   tdo,
  output logic                   tdo_oe,
  output logic [2:0]             pullup_en,
  // Pad path between core and pads
  input  wire logic [11:0]       core_out,
  input  wire logic [11:0]       core_oe,
  input  wire logic [11:0]       pad_in,
  output logic [11:0]            pad_out,
  output logic [11:0]            pad_oe,
  // User code bytes from nonvolatile memory
  input  wire logic [23:0]       product_id,
  input  wire logic [7:0]        version_byte,
  // Internal register access on core_clk
  output logic                   host_if_off,
  output logic [REG_AW-1:0]      reg_raddr,
  input  wire logic [REG_DW-1:0] reg_rdata,
  output logic [REG_AW-1:0]      reg_waddr,
  output logic [REG_DW-1:0]      reg_wdata,
  output logic                   reg_we
);

  // Refuse access widths the data chain cannot carry
  generate
    if (REG_AW + REG_DW > bst_pkg::DR_MAX || REG_AW > REG_DW) begin : g_bad
      $error("bst_tap: register widths do not fit the data chain");
    end
  endgenerate

  // TAP state and instruction
  bst_pkg::bst_state_t st_ff;                // Controller state
  bst_pkg::bst_state_t nxt_st;               // Next state from tms
  logic [3:0]          ir_sh_ff;             // Instruction shift stage
  logic [3:0]          ir_ff;                // Active instruction
  // Data chains
  logic [31:0]         dr_sh_ff;             // Shared data shift chain
  logic [31:0]         nxt_dr_sh;            // Chain after one shift
  logic [31:0]         dr_cap;               // Capture value
  logic [32:0]         dr_up;                // Chain with zero above
  logic [5:0]          dr_len;               // Active chain length
  logic [23:0]         bsr_upd_ff;           // Boundary update latches
  logic [23:0]         bsr_cap;              // Boundary capture values
  // Register access state on tck
  logic                if_off_ff;            // Host interfaces disabled
  logic [REG_AW-1:0]   addr_ff;              // Current read address
  logic [REG_AW-1:0]   wr_addr_ff;           // Write address held
  logic [REG_DW-1:0]   wr_data_ff;           // Write data held
  logic                rd_tog_ff;            // Read fetch event
  logic                wr_tog_ff;            // Write event
  // Output stage on falling tck
  logic                tdo_ff;
  logic                tdo_oe_ff;
  // Synchronisers into the tck domain
  logic [bst_pkg::NSYNC-1:0] in_s1_ff;       // First stage only
  logic [bst_pkg::NSYNC-1:0] in_s2_ff;       // Safe to read
  // Core domain
  logic [2:0]          cx_s1_ff;             // First stage only
  logic [2:0]          cx_s2_ff;
  logic [2:0]          cx_s3_ff;             // Edge detect history
  logic [REG_AW-1:0]   reg_raddr_ff;
  logic [REG_DW-1:0]   rd_data_ff;           // Fetched read data
  logic                rd_pend_ff;
  logic [REG_AW-1:0]   reg_waddr_ff;
  logic [REG_DW-1:0]   reg_wdata_ff;
  logic                reg_we_ff;

  // Pull-ups stay on so a floating port never clocks
  assign pullup_en = 3'h7;

  // Synchronised inputs, split by use
  wire [11:0] pad_s  = in_s2_ff[11:0];
  wire [11:0] coe_s  = in_s2_ff[23:12];
  wire [11:0] cout_s = in_s2_ff[35:24];
  wire [7:0]  ver_s  = in_s2_ff[43:36];
  wire [23:0] prod_s = in_s2_ff[67:44];

  // Instruction decode; access commands exist only while interfaces are off
  wire rd_on   = if_off_ff & (ir_ff == bst_pkg::IR_REGRD);
  wire wr_on   = if_off_ff & (ir_ff == bst_pkg::IR_REGWR);
  wire sel_bsr = (ir_ff == bst_pkg::IR_PRELOAD) | (ir_ff == bst_pkg::IR_EXTEST);
  wire sel_id  = ir_ff == bst_pkg::IR_IDCODE;
  wire sel_usr = ir_ff == bst_pkg::IR_USERCODE;
  wire sel_if  = ir_ff == bst_pkg::IR_IFONOFF;
  // Clamp, high-Z and all undefined codes fall through to bypass
  wire sel_byp = ~(sel_bsr | sel_id | sel_usr | sel_if | rd_on | wr_on);
  wire test_on = (ir_ff == bst_pkg::IR_EXTEST) | (ir_ff == bst_pkg::IR_CLAMP)
               | (ir_ff == bst_pkg::IR_HIGHZ);
  wire hiz_on  = ir_ff == bst_pkg::IR_HIGHZ;
  wire in_shift = (st_ff == bst_pkg::ST_SHDR) | (st_ff == bst_pkg::ST_SHIR);
  wire rd_fetch = ((st_ff == bst_pkg::ST_UPDR) & rd_on)
                | ((st_ff == bst_pkg::ST_UPIR) & if_off_ff
                   & (ir_sh_ff == bst_pkg::IR_REGRD));

  // Chain length by instruction
  assign dr_len = sel_bsr ? 6'(bst_pkg::LEN_BSR) :
                  (sel_id | sel_usr) ? 6'(bst_pkg::LEN_ID) :
                  rd_on ? 6'(REG_DW) :
                  wr_on ? 6'(REG_AW + REG_DW) :
                  6'(bst_pkg::LEN_BYPASS);

  // Capture value by instruction; bypass captures zero
  wire [31:0] id_word  = {ID_VERSION, ID_PART, ID_MANUF, bst_pkg::ID_LSB};
  wire [31:0] usr_word = {ver_s, prod_s};
  assign dr_cap = sel_bsr ? {8'h00, bsr_cap} :
                  sel_id  ? id_word :
                  sel_usr ? usr_word :
                  sel_if  ? {31'h00000000, if_off_ff} :
                  rd_on   ? 32'(rd_data_ff) :
                  32'h00000000;

  // Shift: tdi enters at the top bit of the active length
  assign dr_up = {1'b0, dr_sh_ff};
  genvar gi;
  generate
    for (gi = 0; gi < bst_pkg::DR_MAX; gi++) begin : g_shift
      localparam logic [5:0] POS = 6'(gi + 1);
      assign nxt_dr_sh[gi] = (dr_len == POS) ? tdi :
                             (dr_len > POS) ? dr_up[gi+1] : 1'b0;
    end
  endgenerate

  // Boundary cells: 11 pads with data cell and enable cell above it
  generate
    for (gi = 0; gi < bst_pkg::NCTL; gi++) begin : g_cell
      localparam int DC = (gi < bst_pkg::LOW_PADS) ? 2 * gi : 2 * gi + 2;
      localparam int PI = (gi < bst_pkg::LOW_PADS) ? gi : gi + 1;
      localparam int OC = (PI == bst_pkg::PAD_IF2) ? bst_pkg::CELL_OUT2 : DC;
      // Data cell observes the pad, enable cell observes the core enable
      assign bsr_cap[DC]   = pad_s[PI];
      assign bsr_cap[DC+1] = coe_s[PI];
      // Under test the latched cells own the pad
      assign pad_out[PI] = test_on ? bsr_upd_ff[OC] : core_out[PI];
      assign pad_oe[PI]  = hiz_on ? 1'b0 :
                           test_on ? bsr_upd_ff[DC+1] : core_oe[PI];
    end
  endgenerate
  // Extra output cell observes core data, input cell observes its pad
  assign bsr_cap[bst_pkg::CELL_OUT2] = cout_s[bst_pkg::PAD_IF2];
  assign bsr_cap[bst_pkg::CELL_IN]   = pad_s[bst_pkg::PAD_IF3];
  // Input-only pad has no enable cell, so tests just release it
  assign pad_out[bst_pkg::PAD_IF3] = core_out[bst_pkg::PAD_IF3];
  assign pad_oe[bst_pkg::PAD_IF3]  = test_on ? 1'b0 : core_oe[bst_pkg::PAD_IF3];

  // TAP next state from current state and sampled tms
  always_comb begin
    nxt_st = bst_pkg::ST_TLR;
    case (st_ff)
      bst_pkg::ST_TLR:   nxt_st = tms ? bst_pkg::ST_TLR   : bst_pkg::ST_RTI;
      bst_pkg::ST_RTI:   nxt_st = tms ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
      bst_pkg::ST_SELDR: nxt_st = tms ? bst_pkg::ST_SELIR : bst_pkg::ST_CAPDR;
      bst_pkg::ST_CAPDR: nxt_st = tms ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
      bst_pkg::ST_SHDR:  nxt_st = tms ? bst_pkg::ST_EX1DR : bst_pkg::ST_SHDR;
      bst_pkg::ST_EX1DR: nxt_st = tms ? bst_pkg::ST_UPDR  : bst_pkg::ST_PAUDR;
      bst_pkg::ST_PAUDR: nxt_st = tms ? bst_pkg::ST_EX2DR : bst_pkg::ST_PAUDR;
      bst_pkg::ST_EX2DR: nxt_st = tms ? bst_pkg::ST_UPDR  : bst_pkg::ST_SHDR;
      bst_pkg::ST_UPDR:  nxt_st = tms ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
      bst_pkg::ST_SELIR: nxt_st = tms ? bst_pkg::ST_TLR   : bst_pkg::ST_CAPIR;
      bst_pkg::ST_CAPIR: nxt_st = tms ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
      bst_pkg::ST_SHIR:  nxt_st = tms ? bst_pkg::ST_EX1IR : bst_pkg::ST_SHIR;
      bst_pkg::ST_EX1IR: nxt_st = tms ? bst_pkg::ST_UPIR  : bst_pkg::ST_PAUIR;
      bst_pkg::ST_PAUIR: nxt_st = tms ? bst_pkg::ST_EX2IR : bst_pkg::ST_PAUIR;
      bst_pkg::ST_EX2IR: nxt_st = tms ? bst_pkg::ST_UPIR  : bst_pkg::ST_SHIR;
      bst_pkg::ST_UPIR:  nxt_st = tms ? bst_pkg::ST_SELDR : bst_pkg::ST_RTI;
      default:           nxt_st = bst_pkg::ST_TLR; // Illegal code recovers
    endcase
  end

  // State register; no edge means no change when tck stops
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      st_ff <= bst_pkg::ST_TLR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Input synchronisers for pads, core pad controls and user code
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      in_s1_ff <= '0;
      in_s2_ff <= '0;
    end else begin
      in_s1_ff <= {product_id, version_byte, core_out, core_oe, pad_in};
      in_s2_ff <= in_s1_ff;
    end
  end

  // Instruction path; Test-Logic-Reset forces IDCODE
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      ir_sh_ff <= bst_pkg::IR_CAPTURE;
      ir_ff    <= bst_pkg::IR_IDCODE;
    end else begin
      if (st_ff == bst_pkg::ST_CAPIR) begin
        ir_sh_ff <= bst_pkg::IR_CAPTURE;
      end else if (st_ff == bst_pkg::ST_SHIR) begin
        ir_sh_ff <= {tdi, ir_sh_ff[3:1]};
      end
      if (nxt_st == bst_pkg::ST_TLR) begin
        ir_ff <= bst_pkg::IR_IDCODE;
      end else if (st_ff == bst_pkg::ST_UPIR) begin
        ir_ff <= ir_sh_ff;
      end
    end
  end

  // Data chain; a write keeps its shifted content for the write itself
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      dr_sh_ff <= '0;
    end else if (st_ff == bst_pkg::ST_CAPDR && !wr_on) begin
      dr_sh_ff <= dr_cap;
    end else if (st_ff == bst_pkg::ST_SHDR) begin
      dr_sh_ff <= nxt_dr_sh;
    end
  end

  // Update-DR effects: cell latches, interface switch, read address
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      bsr_upd_ff <= '0;
      if_off_ff  <= 1'b0;
      addr_ff    <= '0;
    end else begin
      if (st_ff == bst_pkg::ST_UPDR && sel_bsr) begin
        bsr_upd_ff <= dr_sh_ff[23:0];
      end
      // Leaving test mode through reset restores the host interfaces
      if (nxt_st == bst_pkg::ST_TLR) begin
        if_off_ff <= 1'b0;
      end else if (st_ff == bst_pkg::ST_UPDR && sel_if) begin
        if_off_ff <= dr_sh_ff[0];
      end
      if (st_ff == bst_pkg::ST_UPDR && rd_on) begin
        addr_ff <= dr_sh_ff[REG_AW-1:0];
      end
    end
  end

  // Events toward the core: read fetch and write at capture
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      rd_tog_ff  <= 1'b0;
      wr_tog_ff  <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
    end else begin
      if (rd_fetch) begin
        rd_tog_ff <= ~rd_tog_ff;
      end
      if (st_ff == bst_pkg::ST_CAPDR && wr_on) begin
        wr_addr_ff <= dr_sh_ff[REG_AW+REG_DW-1:REG_DW];
        wr_data_ff <= dr_sh_ff[REG_DW-1:0];
        wr_tog_ff  <= ~wr_tog_ff;
      end
    end
  end

  // tdo launches on the falling edge for the next device's rising edge
  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      tdo_ff    <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff    <= (st_ff == bst_pkg::ST_SHIR) ? ir_sh_ff[0] : dr_sh_ff[0];
      tdo_oe_ff <= in_shift;
    end
  end
  assign tdo    = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // Core side: toggles cross by two flops, data words are held stable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cx_s1_ff <= '0;
      cx_s2_ff <= '0;
      cx_s3_ff <= '0;
    end else if (core_ce) begin
      cx_s1_ff <= {rd_tog_ff, wr_tog_ff, if_off_ff};
      cx_s2_ff <= cx_s1_ff;
      cx_s3_ff <= cx_s2_ff;
    end
  end
  wire rd_evt = cx_s2_ff[2] ^ cx_s3_ff[2];
  wire wr_evt = cx_s2_ff[1] ^ cx_s3_ff[1];

  // Read fetch: latch address, then sample data one cycle later
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_raddr_ff <= '0;
      rd_data_ff   <= '0;
      rd_pend_ff   <= 1'b0;
    end else if (core_ce) begin
      if (rd_evt) begin
        reg_raddr_ff <= addr_ff;
        rd_pend_ff   <= 1'b1;
      end else if (rd_pend_ff) begin
        rd_data_ff <= reg_rdata;
        rd_pend_ff <= 1'b0;
      end
    end
  end

  // Write strobe: one core cycle per capture event
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reg_waddr_ff <= '0;
      reg_wdata_ff <= '0;
      reg_we_ff    <= 1'b0;
    end else if (core_ce) begin
      reg_we_ff <= wr_evt;
      if (wr_evt) begin
        reg_waddr_ff <= wr_addr_ff;
        reg_wdata_ff <= wr_data_ff;
      end
    end
  end
  assign host_if_off = cx_s2_ff[0];
  assign reg_raddr   = reg_raddr_ff;
  assign reg_waddr   = reg_waddr_ff;
  assign reg_wdata   = reg_wdata_ff;
  assign reg_we      = reg_we_ff;

  // Checks on the tck side
  chk_five_tms_reset: assert property (@(posedge tck) disable iff (!resetn)
    tms [*5] |=> st_ff == bst_pkg::ST_TLR)
    else $error("five tms highs did not reach reset");
  chk_reset_idcode: assert property (@(posedge tck) disable iff (!resetn)
    st_ff == bst_pkg::ST_TLR |-> ir_ff == bst_pkg::IR_IDCODE)
    else $error("reset state without IDCODE");
  chk_tdo_idle_off: assert property (@(posedge tck) disable iff (!resetn)
    tdo_oe == in_shift)
    else $error("tdo driven outside shift");
  chk_bypass_path: assert property (@(posedge tck) disable iff (!resetn)
    (st_ff == bst_pkg::ST_SHDR && sel_byp) ##1 (st_ff == bst_pkg::ST_SHDR)
    |-> tdo == $past(tdi))
    else $error("bypass did not delay tdi by one");
  chk_idcode_lsb: assert property (@(posedge tck) disable iff (!resetn)
    (st_ff == bst_pkg::ST_CAPDR && sel_id) |=> dr_sh_ff == id_word)
    else $error("ID code capture wrong");
  chk_ifoff_update: assert property (@(posedge tck) disable iff (!resetn)
    (st_ff == bst_pkg::ST_UPDR && sel_if && nxt_st != bst_pkg::ST_TLR)
    |=> if_off_ff == $past(dr_sh_ff[0]))
    else $error("interface bit not taken at update");
  chk_read_addr: assert property (@(posedge tck) disable iff (!resetn)
    (st_ff == bst_pkg::ST_UPDR && rd_on) |=> addr_ff == $past(dr_sh_ff[REG_AW-1:0]))
    else $error("read address not updated");
  chk_highz_pads: assert property (@(posedge tck) disable iff (!resetn)
    hiz_on |-> pad_oe == 12'h000)
    else $error("pads driven in high-Z");
  chk_dr_length: assert property (@(posedge tck) disable iff (!resetn)
    (st_ff == bst_pkg::ST_SHDR && sel_bsr) |=> dr_sh_ff[31:24] == 8'h00)
    else $error("boundary chain longer than 24");
  // Check on the core side
  chk_write_strobe: assert property (@(posedge core_clk) disable iff (!resetn)
    (core_ce && wr_evt) |=> reg_we && reg_waddr == $past(wr_addr_ff))
    else $error("write strobe missing or wrong address");

endmodule
`default_nettype wire

//--- sim/bst_jtag_ctl.sv
// Purpose: Model of the external test controller on the scan pins.
// Assumes: tck period 160 ns; tck stands low between frames.
// Notes:   Pins change only while tck is low; tdo taken at rising tck.
`timescale 1ns/1ps
`default_nettype none
module bst_jtag_ctl (
  // Scan pins toward the port
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  // Answer from the port
  input  wire logic tdo
);
  // Idle tms and tdi levels match what the pin pull-ups would give; tck idles low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // One tck period; pins move right after the falling edge
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 tck = 1'b1;
    q = tdo;
    #80 tck = 1'b0;
  endtask
  // One scan from Run-Test/Idle back to Run-Test/Idle, LSB first
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, q);
    if (ir) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
    step(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);  // Back to idle, tdi at pull-up level
  endtask
  // Five tms highs from anywhere, then settle in Run-Test/Idle
  task automatic reset5();
    logic q;
    repeat (5) step(1'b1, 1'b1, q);
    step(1'b0, 1'b1, q);
  endtask
endmodule
`default_nettype wire

//--- sim/tb_top.sv
// Purpose: Self-checking bench of the boundary scan test port.
// Assumes: core_clk 40 MHz, tck 160 ns from the controller model.
// Notes:   Register file is modelled by a fixed function of the address.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [3:0]  ID_V = 4'h5;      // Arbitrary value
  localparam logic [15:0] ID_P = 16'hA5C3;  // Arbitrary value
  localparam logic [10:0] ID_M = 11'h1D7;   // Arbitrary value
  localparam logic [31:0] ID_W = {ID_V, ID_P, ID_M, bst_pkg::ID_LSB};
  logic        core_clk, resetn, tck, tms, tdi, tdo, tdo_oe, host_if_off, reg_we;
  logic        core_ce;
  logic [2:0]  pullup_en;
  logic [11:0] core_out, core_oe, pad_in, pad_out, pad_oe;
  logic [23:0] product_id;
  logic [7:0]  version_byte, reg_rdata, reg_wdata, wd;
  logic [6:0]  reg_raddr, reg_waddr, wa;
  logic [31:0] got;
  int          fails, checks_done;
  int          n_wr = 0;
  // Register file answer, derived from the address alone
  assign reg_rdata = {reg_raddr, 1'b1} ^ 8'h3C;
  bst_jtag_ctl u_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  bst_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MANUF(ID_M)) u_dut (
    .core_clk(core_clk), .resetn(resetn), .core_ce(core_ce), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pullup_en(pullup_en),
    .core_out(core_out), .core_oe(core_oe), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .product_id(product_id), .version_byte(version_byte),
    .host_if_off(host_if_off), .reg_raddr(reg_raddr), .reg_rdata(reg_rdata),
    .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .reg_we(reg_we));
  // Core clock
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Count write pulses and keep the last address and data
  always @(posedge core_clk) begin
    if (reg_we === 1'b1) begin
      n_wr++;
      wa = reg_waddr;
      wd = reg_wdata;
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic t_idcode();
    u_ctl.reset5();
    u_ctl.scan(0, 32, 32'h0, got);
    chk(got, ID_W);
    chk(tdo_oe, 1'b0);
    chk(pullup_en, 3'h7);
  endtask
  task automatic t_bypass();
    logic [3:0] codes [4];
    codes = '{bst_pkg::IR_BYPASS, bst_pkg::IR_CLAMP, bst_pkg::IR_HIGHZ, 4'hB};
    foreach (codes[k]) begin
      u_ctl.scan(1, 4, codes[k], got);
      chk(got[3:0], bst_pkg::IR_CAPTURE);
      u_ctl.scan(0, 8, 32'hB5, got);
      chk(got[7:0], 8'h6A);
    end
  endtask
  task automatic t_user();
    u_ctl.scan(1, 4, bst_pkg::IR_USERCODE, got);
    #3000;  // tck stands still meanwhile
    u_ctl.scan(0, 32, 32'h0, got);
    chk(got, {version_byte, product_id});
  endtask
  task automatic t_reset();
    logic q;
    u_ctl.step(1'b1, 1'b1, q);
    u_ctl.step(1'b0, 1'b1, q);
    u_ctl.step(1'b0, 1'b1, q);
    u_ctl.reset5();
    u_ctl.scan(0, 32, 32'h0, got);
    chk(got, ID_W);
  endtask
  task automatic t_pads();
    u_ctl.scan(1, 4, bst_pkg::IR_PRELOAD, got);
    u_ctl.scan(0, 24, 32'h2A4C72, got);
    chk(pad_out, 12'hFFF);
    u_ctl.scan(1, 4, bst_pkg::IR_EXTEST, got);
    chk({pad_out[4], pad_out[0], pad_oe[0], pad_oe[3], pad_oe[11]}, 5'h04);
    u_ctl.scan(0, 24, 32'h2A4C72, got);
    chk({got[8], got[6]}, 2'h3);
    u_ctl.scan(1, 4, bst_pkg::IR_HIGHZ, got);
    chk(pad_oe, 12'h000);
    // Clamp drives every pad but the input-only one from the latched cells, enables included
    u_ctl.scan(1, 4, bst_pkg::IR_CLAMP, got);
    chk({pad_out, pad_oe}, {12'h0AC, 12'h725});
  endtask
  task automatic t_regs();
    int n0;
    u_ctl.scan(1, 4, bst_pkg::IR_IFONOFF, got);
    u_ctl.scan(0, 1, 32'h1, got);
    #500;
    chk(host_if_off, 1'b1);
    u_ctl.scan(1, 4, bst_pkg::IR_REGWR, got);
    u_ctl.scan(0, 15, {7'h35, 8'hC6}, got);
    #500 n0 = n_wr;
    u_ctl.scan(0, 15, 32'h0, got);
    #500;
    chk(n_wr - n0, 1);
    chk({wa, wd}, {7'h35, 8'hC6});
    u_ctl.scan(1, 4, bst_pkg::IR_REGRD, got);
    u_ctl.scan(0, 8, 32'h35, got);
    #500;
    chk(reg_raddr, 7'h35);
    u_ctl.scan(0, 8, 32'h0, got);
    chk(got[7:0], {7'h35, 1'b1} ^ 8'h3C);
  endtask
  // A write event raised while the core is frozen waits for the enable
  task automatic t_freeze();
    int n0;
    u_ctl.scan(1, 4, bst_pkg::IR_REGWR, got);
    u_ctl.scan(0, 15, {7'h4A, 8'h1E}, got);
    #500 n0 = n_wr;
    @(posedge core_clk);
    #2 core_ce = 1'b0;
    u_ctl.scan(0, 15, 32'h0, got);
    #500;
    chk(n_wr - n0, 0);
    chk(host_if_off, 1'b1);
    @(posedge core_clk);
    #2 core_ce = 1'b1;
    #500;
    chk(n_wr - n0, 1);
    chk({wa, wd}, {7'h4A, 8'h1E});
  endtask
  task automatic complete_run();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run of about 83 us
  initial begin
    #1000000;
    fails++;
    complete_run();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    core_ce = 1'b1;
    core_out = 12'hFFF;
    core_oe = 12'hFFF;
    pad_in = 12'h018;
    product_id = 24'hC3B2A1;
    version_byte = 8'h4E;
    fails = 0;
    checks_done = 0;
    repeat (16) @(posedge core_clk);
    #2 resetn = 1'b1;
    #7;
    t_idcode();
    t_bypass();
    t_user();
    t_reset();
    t_pads();
    t_regs();
    t_freeze();
    complete_run();
  end
endmodule
`default_nettype wire
